// file: core/clock_switch_params.svh
`ifndef CLOCK_SWITCH_PARAMS_SVH
`define CLOCK_SWITCH_PARAMS_SVH
// Operation
// - Bypass clear: secondary oscillator runs as crystal across both pins.
// - Switch-complete flag is 1 when current equals requested selection.
// - External, fast, slow, secondary ready flags read 1 only when usable.
// - Converter RC ready flag at status bit 2 reads 1 once usable.
// - Ready flags read 0 when disabled or not yet stable.
// - Bypass set: input pin is external clock input, output pin unused.
// - Hold clear switches when requested source ready; set holds, interrupts.

// Register addresses
`define ADDR_CONTROL_THREE 4'h0
`define ADDR_READY_STATUS  4'h1
`define ADDR_REQUESTED     4'h2
`define ADDR_CURRENT       4'h3
`define ADDR_IRQ_STATUS    4'h4
`define ADDR_IRQ_MASK      4'h5

// Control three fields
`define BIT_HOLD           7
`define BIT_BYPASS         5
`define BIT_COMPLETE       4
`define BIT_REQ_READY      3

// Ready status fields
`define BIT_EXT_READY      7
`define BIT_FAST_READY     6
`define BIT_SLOW_READY     4
`define BIT_SEC_READY      3
`define BIT_RC_READY       2
`define BIT_PLL_READY      0

// Interrupt status fields
`define BIT_IRQ_HELD       0
`define BIT_IRQ_DONE       1

`define RESET_BYTE         8'h00
`define RESET_SELECT       3'h0
`endif

// file: core/clock_switch_pkg.sv
package clock_switch_pkg;
  // Oscillator sources, indexed by the select code
  typedef enum logic [2:0]
  {
    SRC_EXT  = 3'h0,
    SRC_FAST = 3'h1,
    SRC_SLOW = 3'h2,
    SRC_SEC  = 3'h3,
    SRC_RC   = 3'h4,
    SRC_PLL  = 3'h5
  } source_t;

  // Raw oscillator condition from the analog side
  typedef struct packed
  {
    logic ext;
    logic fast;
    logic slow;
    logic sec;
    logic rc;
    logic pll;
  } osc_flags_t;

  typedef enum logic [0:0]
  {
    SW_IDLE = 1'b0,
    SW_HELD = 1'b1
  } switch_state_t;
endpackage

// file: core/clock_switch_ready_status.sv
// Added by the designer: the strobed register port and the register addresses.
`include "clock_switch_params.svh"

module clock_switch_ready_status
#(
  parameter int ADDR_WIDTH = 4
)
(
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic [ADDR_WIDTH-1:0]       regAddr,
  input  wire logic [7:0]                  regWdata,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [7:0]                  regRdata,
  input  wire clock_switch_pkg::osc_flags_t oscEnabled,
  input  wire clock_switch_pkg::osc_flags_t oscStable,
  input  wire logic                        pllSourceReady,
  input  wire logic                        secondary_xtal_in_pin,
  output logic                             secondaryXtalOut,
  output logic                             secondaryXtalOutEn,
  output logic                             secondaryClock,
  output logic                             crystalDriveEn,
  output logic [2:0]                       systemSource,
  output logic                             irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  clock_switch_pkg::osc_flags_t enMeta, enSync, stMeta, stSync;
  logic pllSrcMeta, pllSrcSync, secInMeta, secInSync;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      enMeta     <= '0;
      enSync     <= '0;
      stMeta     <= '0;
      stSync     <= '0;
      pllSrcMeta <= 1'b0;
      pllSrcSync <= 1'b0;
      secInMeta  <= 1'b0;
      secInSync  <= 1'b0;
    end
    else
    begin
      enMeta     <= oscEnabled;
      enSync     <= enMeta;
      stMeta     <= oscStable;
      stSync     <= stMeta;
      pllSrcMeta <= pllSourceReady;
      pllSrcSync <= pllSrcMeta;
      secInMeta  <= secondary_xtal_in_pin;
      secInSync  <= secInMeta;
    end
  end

  // ****************************************
  // Ready flags
  // ****************************************
  clock_switch_pkg::osc_flags_t ready;

  always_comb
  begin
    ready     = enSync & stSync;
    ready.pll = enSync.pll & stSync.pll & pllSrcSync;
  end

  function automatic logic sourceReady(input logic [2:0] sel,
                                       input clock_switch_pkg::osc_flags_t r);
    logic res;
    res = 1'b0;
    case (sel)
      clock_switch_pkg::SRC_EXT:  res = r.ext;
      clock_switch_pkg::SRC_FAST: res = r.fast;
      clock_switch_pkg::SRC_SLOW: res = r.slow;
      clock_switch_pkg::SRC_SEC:  res = r.sec;
      clock_switch_pkg::SRC_RC:   res = r.rc;
      clock_switch_pkg::SRC_PLL:  res = r.pll;
      default:                    res = 1'b0;
    endcase
    return res;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic       holdReg, bypassReg;
  logic [2:0] requestedReg, currentReg;
  logic [1:0] irqStatusReg, irqMaskReg;
  logic       reqReady, complete, held;
  clock_switch_pkg::switch_state_t stateReg;

  assign reqReady = sourceReady(requestedReg, ready);
  assign complete = (requestedReg == currentReg);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      holdReg      <= 1'b0;
      bypassReg    <= 1'b0;
      requestedReg <= `RESET_SELECT;
      irqMaskReg   <= '0;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `ADDR_CONTROL_THREE:
        begin
          holdReg   <= regWdata[`BIT_HOLD];
          bypassReg <= regWdata[`BIT_BYPASS];
        end
        `ADDR_REQUESTED: requestedReg <= regWdata[2:0];
        `ADDR_IRQ_MASK:  irqMaskReg   <= regWdata[1:0];
        default:         ;
      endcase
    end
  end

  // ****************************************
  // Clock switch sequencer
  // ****************************************
  // A switch waits in HELD while hold is set; clearing hold lets it go
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      currentReg <= `RESET_SELECT;
      stateReg   <= clock_switch_pkg::SW_IDLE;
    end
    else
    begin
      unique case (stateReg)
        clock_switch_pkg::SW_IDLE:
        begin
          if (!complete && reqReady)
          begin
            if (holdReg)
              stateReg <= clock_switch_pkg::SW_HELD;
            else
              currentReg <= requestedReg;
          end
        end
        clock_switch_pkg::SW_HELD:
        begin
          if (complete || !reqReady)
            stateReg <= clock_switch_pkg::SW_IDLE;
          else if (!holdReg)
          begin
            currentReg <= requestedReg;
            stateReg   <= clock_switch_pkg::SW_IDLE;
          end
        end
      endcase
    end
  end

  assign held = (stateReg == clock_switch_pkg::SW_IDLE) && !complete
                && reqReady && holdReg;

  // ****************************************
  // Interrupts
  // ****************************************
  logic [1:0] irqEvents;
  logic       switchedNow;

  assign switchedNow = !complete && reqReady && !holdReg;
  assign irqEvents   = {switchedNow, held};

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irqStatusReg <= '0;
    else if (regWrite && regAddr == `ADDR_IRQ_STATUS)
      irqStatusReg <= (irqStatusReg & ~regWdata[1:0]) | irqEvents;
    else
      irqStatusReg <= irqStatusReg | irqEvents;
  end

  assign irq = |(irqStatusReg & irqMaskReg);

  // ****************************************
  // Secondary oscillator pins
  // ****************************************
  // Crystal mode drives the output pin as inverter output of the input
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      secondaryXtalOut   <= 1'b0;
      secondaryXtalOutEn <= 1'b0;
      crystalDriveEn     <= 1'b0;
      secondaryClock     <= 1'b0;
    end
    else
    begin
      crystalDriveEn     <= !bypassReg && enSync.sec;
      secondaryXtalOutEn <= !bypassReg && enSync.sec;
      secondaryXtalOut   <= !bypassReg && !secInSync;
      secondaryClock     <= secInSync;
    end
  end

  assign systemSource = currentReg;

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      regRdata <= `RESET_BYTE;
    else if (regRead)
    begin
      regRdata <= `RESET_BYTE;
      unique case (regAddr)
        `ADDR_CONTROL_THREE:
        begin
          regRdata[`BIT_HOLD]      <= holdReg;
          regRdata[`BIT_BYPASS]    <= bypassReg;
          regRdata[`BIT_COMPLETE]  <= complete;
          regRdata[`BIT_REQ_READY] <= reqReady;
        end
        `ADDR_READY_STATUS:
        begin
          regRdata[`BIT_EXT_READY]  <= ready.ext;
          regRdata[`BIT_FAST_READY] <= ready.fast;
          regRdata[`BIT_SLOW_READY] <= ready.slow;
          regRdata[`BIT_SEC_READY]  <= ready.sec;
          regRdata[`BIT_RC_READY]   <= ready.rc;
          regRdata[`BIT_PLL_READY]  <= ready.pll;
        end
        `ADDR_REQUESTED:  regRdata[2:0] <= requestedReg;
        `ADDR_CURRENT:    regRdata[2:0] <= currentReg;
        `ADDR_IRQ_STATUS: regRdata[1:0] <= irqStatusReg;
        `ADDR_IRQ_MASK:   regRdata[1:0] <= irqMaskReg;
        default:          ;
      endcase
    end
    else
      regRdata <= `RESET_BYTE;
  end

endmodule

// file: tb/clock_switch_ready_status_properties.sv
module clock_switch_ready_status_properties
#(
  parameter int ADDR_WIDTH = 4
)
(
  input wire logic                         mclk,
  input wire logic                         reset,
  input wire logic [ADDR_WIDTH-1:0]        regAddr,
  input wire logic [7:0]                   regWdata,
  input wire logic                         regWrite,
  input wire logic                         regRead,
  input wire logic [7:0]                   regRdata,
  input wire clock_switch_pkg::osc_flags_t oscEnabled,
  input wire clock_switch_pkg::osc_flags_t oscStable,
  input wire logic                         pllSourceReady,
  input wire logic                         secondary_xtal_in_pin,
  input wire logic                         secondaryXtalOut,
  input wire logic                         secondaryXtalOutEn,
  input wire logic                         secondaryClock,
  input wire logic                         crystalDriveEn,
  input wire logic [2:0]                   systemSource,
  input wire logic                         irq
);
  // Shadow of the requested selection, rebuilt from bus writes
  logic [2:0] reqSel_reg;
  logic       reqMatch;
  assign reqMatch = systemSource == reqSel_reg;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      reqSel_reg <= 3'h0;
    else if (regWrite && regAddr == 4'h2)
      reqSel_reg <= regWdata[2:0];
  end
  // Shadow of the bypass selection, so the pin check is not self-referential
  logic       bypSel_reg;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      bypSel_reg <= 1'b0;
    else if (regWrite && regAddr == 4'h0)
      bypSel_reg <= regWdata[5];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_RDATA_ZERO: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside reply cycle");
  AST_CUR_READ: assert property (regRead && regAddr == 4'h3 |=>
    regRdata == {5'h00, $past(systemSource)}) else $error("current read");
  AST_COMPLETE: assert property (regRead && regAddr == 4'h0 |=>
    regRdata[4] == $past(reqMatch)) else $error("complete flag");
  AST_GAP_BITS: assert property (regRead && regAddr == 4'h1 |=>
    !regRdata[5] && !regRdata[1]) else $error("unused status bit set");
  AST_ALL_READY: assert property ((oscEnabled == 6'h3F &&
    oscStable == 6'h3F && pllSourceReady)[*5] ##0
    (regRead && regAddr == 4'h1) |=> regRdata == 8'hDD)
    else $error("ready flags missing");
  AST_ALL_OFF: assert property ((oscEnabled == 6'h00)[*5] ##0
    (regRead && regAddr == 4'h1) |=> regRdata == 8'h00)
    else $error("ready while disabled");
  AST_PLL_SRC: assert property ((!pllSourceReady)[*5] ##0
    (regRead && regAddr == 4'h1) |=> !regRdata[0])
    else $error("pll ready without source");
  AST_PIN_UNUSED: assert property ($past(bypSel_reg) |->
    !secondaryXtalOutEn && !crystalDriveEn)
    else $error("output pin driven in bypass");
  AST_SWITCH: assert property ($changed(systemSource) |->
    systemSource == $past(reqSel_reg)) else $error("switch to wrong source");
endmodule

bind clock_switch_ready_status clock_switch_ready_status_properties
  #(.ADDR_WIDTH(ADDR_WIDTH)) checker_i (.*);

// file: tb/clock_switch_ready_status_tb_top.sv
module clock_switch_ready_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       pinIn = 1'b0;
  logic       srcRdy = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [2:0] sysSrc;
  logic       xOut, xOutEn, secClk, drvEn, irq;
  clock_switch_pkg::osc_flags_t oscEn = 6'h00;
  clock_switch_pkg::osc_flags_t oscSt = 6'h00;
  int         n_fail = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         pos[6] = '{0, 2, 3, 4, 6, 7};
  clock_switch_ready_status clock_switch_ready_status_i
  (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .oscEnabled(oscEn), .oscStable(oscSt), .pllSourceReady(srcRdy),
    .secondary_xtal_in_pin(pinIn), .secondaryXtalOut(xOut),
    .secondaryXtalOutEn(xOutEn), .secondaryClock(secClk),
    .crystalDriveEn(drvEn), .systemSource(sysSrc), .irq(irq)
  );
  always #5 mclk = ~mclk;
  // ****************
  // Bus and checking
  // ****************
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Strobe drops before the next call, so no double drive in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 chk(regRdata, e);
    @(posedge mclk);
  endtask
  task automatic t_ready();
    for (int i = 0; i < 6; i++)
    begin
      oscEn <= 6'h01 << i;
      oscSt <= 6'h3F;
      srcRdy <= 1'b1;
      w(4);
      rd(4'h1, 8'h01 << pos[i]);
      oscSt <= 6'h00;
      w(4);
      rd(4'h1, 8'h00);
    end
    oscEn <= 6'h3F;
    oscSt <= 6'h3F;
    srcRdy <= 1'b0;
    w(4);
    rd(4'h1, 8'hDC);
  endtask
  task automatic t_switch();
    oscSt <= 6'h00;
    srcRdy <= 1'b1;
    wr(4'h5, 8'h03);
    wr(4'h2, 8'h03);
    rd(4'h0, 8'h00);
    oscSt <= 6'h3F;
    w(5);
    rd(4'h1, 8'hDD);
    rd(4'h3, 8'h03);
    chk({5'h00, sysSrc}, 8'h03);
    rd(4'h0, 8'h18);
    rd(4'h4, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(4'h4, 8'h02);
    chk({7'h00, irq}, 8'h00);
    // Held switch must wait for the hold bit to drop
    wr(4'h0, 8'h80);
    wr(4'h2, 8'h01);
    w(2);
    rd(4'h3, 8'h03);
    rd(4'h0, 8'h88);
    rd(4'h4, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(4'h5, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(4'h5, 8'h03);
    wr(4'h0, 8'h00);
    w(2);
    wr(4'h3, 8'h05);
    rd(4'h3, 8'h01);
    chk({5'h00, sysSrc}, 8'h01);
    wr(4'h4, 8'h03);
  endtask
  task automatic t_pins();
    chk({drvEn, xOutEn}, 8'h03);
    chk({7'h00, xOut}, 8'h01);
    wr(4'h0, 8'h20);
    w(1);
    chk({drvEn, xOutEn}, 8'h00);
    pinIn <= 1'b1;
    w(5);
    chk({7'h00, secClk}, 8'h01);
    chk({7'h00, xOut}, 8'h00);
    pinIn <= 1'b0;
    w(5);
    chk({7'h00, secClk}, 8'h00);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 8'h10);
    rd(4'h3, 8'h00);
    rd(4'hF, 8'h00);
    rd(4'h1, 8'h00);
    t_ready();
    t_switch();
    t_pins();
    stop_test();
  end
endmodule
